// >>> tpa_line_sink.sv
// Serializer-side model that takes output words with random stalls.
// Assumes valid and words come from flops on the same clock.
`timescale 1ns/1ps
module tpa_line_sink (
  // Clock
  input wire logic i_clk,
  // Word side
  input wire logic i_valid,
  input wire logic [19:0] i_word,
  input wire logic i_stall,
  output logic o_ready
);
  logic [19:0] q[$];
  initial o_ready = 1'b0;
  // Keep every taken word; ready is random and low while stalled
  always @(posedge i_clk) begin
    if (i_valid && o_ready) q.push_back(i_word);
    o_ready <= !i_stall && ($urandom_range(3) != 0);
  end
endmodule // tpa_line_sink

// >>> tpa_pkg.sv
// Constants, types and field layouts of the transmit pattern and polarity
// block. Assumes one clock, the half-rate user clock, for all logic.
// Function
// - With per-channel dividers at one, both transmitters run one line rate.
// - Polarity bit sampled on half-rate clock; 1 swaps positive and negative.
// - Polarity inversion acts on parallel data before serialization.
// - Pattern select 00 data, 01 short, 10 medium, 11 long sequence.
// - Short pattern: 1+x^6+x^7, inverted output, period 2^7-1.
// - Medium pattern: 1+x^18+x^23, inverted output, period 2^23-1.
// - Long pattern: 1+x^28+x^31, inverted output, period 2^31-1.
// - Enable stays high after alignment; dropping it loses alignment.
// - Width select 0 means 8-bit internal path, 1 means 10-bit path.
package tpa_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  // Control register layout, bit 0 is pol0
  typedef struct packed {
    logic buf_use;
    logic [1:0] com_div;
    logic set_phase;
    logic phase_en;
    logic width10;
    logic [1:0] pat1;
    logic [1:0] pat0;
    logic pol1;
    logic pol0;
  } tpa_ctrl_t;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h800;
  // Status bit positions
  localparam int ST_ALIGNED = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FULL = 2;
  localparam int ST_WIDTH_BAD = 3;
  // Common divider codes
  localparam logic [1:0] DIV1 = 2'h0;
  localparam logic [1:0] DIV2 = 2'h1;
  localparam logic [1:0] DIV4 = 2'h2;
  // Pattern selects
  typedef enum logic [1:0] {
    PAT_OFF = 2'h0, PAT_7 = 2'h1, PAT_23 = 2'h2, PAT_31 = 2'h3
  } tpa_pat_t;
  // Feedback tap positions, zero based
  localparam int TAP7A = 6;
  localparam int TAP7B = 5;
  localparam int TAP23A = 22;
  localparam int TAP23B = 17;
  localparam int TAP31A = 30;
  localparam int TAP31B = 27;
  localparam logic [30:0] SEED = 31'h7FFFFFFF;
  localparam int WORD_W = 10;
  // Phase alignment tracker, Gray along the path
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0, PH_ARMED = 2'h1, PH_SETTING = 2'h3, PH_ALIGNED = 2'h2
  } tpa_ph_t;
  // Two channel words moving together
  typedef struct packed {
    logic [9:0] ch1;
    logic [9:0] ch0;
  } tpa_word_t;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> tpa_top.sv
// Transmit side of a two-channel tile: word FIFO, pattern generators,
// polarity and width handling, phase-alignment tracking, AXI4-Lite registers.
// Assumes all inputs come from logic on I_CLK, the half-rate user clock.
`timescale 1ns/1ps

// Word FIFO, depth a power of two
module tpa_fifo #(
  parameter int W = 20,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // Drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic rdy, next_rdy, push, pop;

  // Pointer and count update; ready drops when full
  always_comb begin
    push = i_in_valid && rdy;
    pop = (cnt != '0) && i_out_ready;
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_rdy = next_cnt < (AW+1)'(D);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      rdy <= 1'b1;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      rdy <= next_rdy;
    end
  end

  // Storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp] <= i_in_data;
    end
  end

  assign o_in_ready = rdy;
  assign o_out_valid = cnt != '0;
  assign o_out_data = mem[rp];
endmodule // tpa_fifo

module tpa_top #(
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // AXI4-Lite write
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [3:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [3:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // User words in, ch1 high
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  input wire logic [19:0] I_TX_DATA,
  // Words toward the serializers
  input wire logic I_LINE_READY,
  output logic O_WORD_VALID,
  output logic [9:0] O_CH0_WORD,
  output logic [9:0] O_CH1_WORD,
  // Tile settings and state
  output logic [1:0] O_LINE_DIV,
  output logic O_WIDTH10,
  output logic O_BUF_USE,
  output logic O_ALIGNED
);
  tpa_pkg::tpa_ctrl_t ctrl, next_ctrl;
  logic aw_rdy, w_rdy, aw_got, w_got, bvalid;
  logic next_aw_rdy, next_w_rdy, next_aw_got, next_w_got, next_bvalid;
  logic [3:0] waddr, next_waddr, wstrb, next_wstrb;
  logic [11:0] wdata, next_wdata, raw;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic ar_rdy, rvalid, next_ar_rdy, next_rvalid, do_wr;
  logic [31:0] rdata, next_rdata;
  tpa_pkg::tpa_ph_t ph, next_ph;
  logic aligned, next_aligned;
  tpa_pkg::tpa_word_t fifo_data, out, next_out;
  logic fifo_vld, fifo_rdy, ovalid, next_ovalid, fire;
  logic [1:0][30:0] st, next_st;
  logic [1:0][1:0] pat_q, next_pat_q;

  // Bit-serial step of one generator, ten bits per word, first bit at MSB
  function automatic logic [40:0] prbs10(input logic [30:0] s,
                                         input logic [1:0] m);
    logic [30:0] t;
    logic [9:0] w;
    logic fb;
    int i;
    t = s;
    w = '0;
    fb = 1'b0;
    for (i = 9; i >= 0; i--) begin
      case (m)
        tpa_pkg::PAT_7: fb = t[tpa_pkg::TAP7A] ^ t[tpa_pkg::TAP7B];
        tpa_pkg::PAT_23: fb = t[tpa_pkg::TAP23A] ^ t[tpa_pkg::TAP23B];
        default: fb = t[tpa_pkg::TAP31A] ^ t[tpa_pkg::TAP31B];
      endcase
      t = {t[29:0], fb};
      w[i] = ~fb;
    end
    return {w, t};
  endfunction

  // Write channel: address and data taken in either order, then answered
  always_comb begin
    do_wr = aw_got && w_got && !bvalid;
    next_aw_got = aw_got || (I_AWVALID && aw_rdy);
    next_w_got = w_got || (I_WVALID && w_rdy);
    next_waddr = (I_AWVALID && aw_rdy) ? I_AWADDR : waddr;
    next_wdata = (I_WVALID && w_rdy) ? I_WDATA[11:0] : wdata;
    next_wstrb = (I_WVALID && w_rdy) ? I_WSTRB : wstrb;
    next_bvalid = bvalid && !I_BREADY;
    next_bresp = bresp;
    next_ctrl = ctrl;
    raw = ctrl;
    if (do_wr) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = tpa_pkg::RESP_OKAY;
      if (waddr[3:2] == tpa_pkg::CTRL_OFS[3:2]) begin
        if (wstrb[0]) raw[7:0] = wdata[7:0];
        if (wstrb[1]) raw[11:8] = wdata[11:8];
        next_ctrl = tpa_pkg::tpa_ctrl_t'(raw);
      end else if (waddr[3:2] != tpa_pkg::STAT_OFS[3:2]) begin
        next_bresp = tpa_pkg::RESP_SLVERR;
      end
    end
    next_aw_rdy = !next_aw_got && !next_bvalid;
    next_w_rdy = !next_w_got && !next_bvalid;
  end

  // Read channel: one answer a cycle after the address is taken
  always_comb begin
    next_rvalid = rvalid && !I_RREADY;
    next_rdata = rdata;
    next_rresp = rresp;
    if (I_ARVALID && ar_rdy) begin
      next_rvalid = 1'b1;
      next_rresp = tpa_pkg::RESP_OKAY;
      next_rdata = '0;
      if (I_ARADDR[3:2] == tpa_pkg::CTRL_OFS[3:2]) begin
        next_rdata[tpa_pkg::CTRL_W-1:0] = ctrl;
      end else if (I_ARADDR[3:2] == tpa_pkg::STAT_OFS[3:2]) begin
        next_rdata[tpa_pkg::ST_ALIGNED] = aligned;
        next_rdata[tpa_pkg::ST_EMPTY] = !fifo_vld;
        next_rdata[tpa_pkg::ST_FULL] = !fifo_rdy;
        next_rdata[tpa_pkg::ST_WIDTH_BAD] = !ctrl.width10 &&
          (ctrl.pat0 != tpa_pkg::PAT_OFF || ctrl.pat1 != tpa_pkg::PAT_OFF);
      end else begin
        next_rresp = tpa_pkg::RESP_SLVERR;
      end
    end
    next_ar_rdy = !next_rvalid;
  end

  // Phase alignment tracker
  always_comb begin
    next_ph = ph;
    case (ph)
      tpa_pkg::PH_IDLE: if (ctrl.phase_en) next_ph = tpa_pkg::PH_ARMED;
      tpa_pkg::PH_ARMED: begin
        if (ctrl.set_phase) next_ph = tpa_pkg::PH_SETTING;
      end
      tpa_pkg::PH_SETTING: begin
        if (!ctrl.set_phase) next_ph = tpa_pkg::PH_ALIGNED;
      end
      tpa_pkg::PH_ALIGNED: next_ph = tpa_pkg::PH_ALIGNED;
      default: next_ph = tpa_pkg::PH_IDLE;
    endcase
    if (!ctrl.phase_en) next_ph = tpa_pkg::PH_IDLE;
    next_aligned = next_ph == tpa_pkg::PH_ALIGNED;
  end

  // Data path: pattern or user word, polarity, then width
  always_comb begin
    logic [40:0] g;
    logic [9:0] src;
    logic [1:0] m;
    logic p;
    m = 2'h0;
    p = 1'b0;
    g = '0;
    src = '0;
    fire = fifo_vld && (!ovalid || I_LINE_READY);
    next_ovalid = fire || (ovalid && !I_LINE_READY);
    next_out = out;
    next_st = st;
    for (int c = 0; c < 2; c++) begin
      m = (c == 0) ? ctrl.pat0 : ctrl.pat1;
      p = (c == 0) ? ctrl.pol0 : ctrl.pol1;
      next_pat_q[c] = m;
      if (m == tpa_pkg::PAT_OFF || m != pat_q[c]) begin
        next_st[c] = tpa_pkg::SEED;
        src = (c == 0) ? fifo_data.ch0 : fifo_data.ch1;
      end else begin
        g = prbs10(st[c], m);
        src = g[40:31];
        if (fire) next_st[c] = g[30:0];
      end
      src = src ^ {tpa_pkg::WORD_W{p}};
      if (!ctrl.width10) src[9:8] = 2'h0;
      if (fire && c == 0) next_out.ch0 = src;
      if (fire && c == 1) next_out.ch1 = src;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ctrl <= tpa_pkg::tpa_ctrl_t'(tpa_pkg::CTRL_RST);
      aw_rdy <= 1'b1;
      w_rdy <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 4'h0;
      wdata <= 12'h000;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= tpa_pkg::RESP_OKAY;
      ar_rdy <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= tpa_pkg::RESP_OKAY;
      ph <= tpa_pkg::PH_IDLE;
      aligned <= 1'b0;
      out <= '0;
      ovalid <= 1'b0;
      st <= {2{tpa_pkg::SEED}};
      pat_q <= 4'h0;
    end else begin
      ctrl <= next_ctrl;
      aw_rdy <= next_aw_rdy;
      w_rdy <= next_w_rdy;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      ar_rdy <= next_ar_rdy;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ph <= next_ph;
      aligned <= next_aligned;
      out <= next_out;
      ovalid <= next_ovalid;
      st <= next_st;
      pat_q <= next_pat_q;
    end
  end

  tpa_fifo #(.W(20), .D(DEPTH)) u_fifo (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_in_valid(I_TX_VALID),
    .o_in_ready(fifo_rdy),
    .i_in_data(I_TX_DATA),
    .o_out_valid(fifo_vld),
    .i_out_ready(fire),
    .o_out_data(fifo_data)
  );

  // Outputs, all from flops
  assign O_AWREADY = aw_rdy;
  assign O_WREADY = w_rdy;
  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;
  assign O_ARREADY = ar_rdy;
  assign O_RVALID = rvalid;
  assign O_RDATA = rdata;
  assign O_RRESP = rresp;
  assign O_TX_READY = fifo_rdy;
  assign O_WORD_VALID = ovalid;
  assign O_CH0_WORD = out.ch0;
  assign O_CH1_WORD = out.ch1;
  assign O_LINE_DIV = ctrl.com_div;
  assign O_WIDTH10 = ctrl.width10;
  assign O_BUF_USE = ctrl.buf_use;
  assign O_ALIGNED = aligned;

  // Checks
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Set-phase held two cycles under enable, then dropped, reaches the aligned state
  sequence s_set_held;
    ctrl.phase_en && ctrl.set_phase ##1 ctrl.phase_en && ctrl.set_phase;
  endsequence
  sequence s_set_done;
    s_set_held ##1 ctrl.phase_en && !ctrl.set_phase;
  endsequence
  property p_align;
    s_set_done |=> O_ALIGNED;
  endproperty
  a_align: assert property (p_align) else $error("align lost");
  property p_unalign;
    !ctrl.phase_en |=> !O_ALIGNED;
  endproperty
  a_unalign: assert property (p_unalign) else $error("still aligned");
  property p_pol;
    fire && ctrl.pol0 && ctrl.width10 && ctrl.pat0 == tpa_pkg::PAT_OFF
      |=> O_CH0_WORD == ~$past(fifo_data.ch0) && O_WORD_VALID;
  endproperty
  a_pol: assert property (p_pol) else $error("bad inversion");
  property p_plain;
    fire && !ctrl.pol1 && ctrl.width10 && ctrl.pat1 == tpa_pkg::PAT_OFF
      |=> O_CH1_WORD == $past(fifo_data.ch1);
  endproperty
  a_plain: assert property (p_plain) else $error("data altered");
  property p_w8;
    fire && !ctrl.width10 |=> O_CH0_WORD[9:8] == 2'h0 &&
      O_CH1_WORD[9:8] == 2'h0;
  endproperty
  a_w8: assert property (p_w8) else $error("8-bit leak");
  property p_p7;
    pat_q[0] == tpa_pkg::PAT_7 |-> st[0][6:0] != 7'h00;
  endproperty
  a_p7: assert property (p_p7) else $error("short stuck");
  property p_p23;
    pat_q[0] == tpa_pkg::PAT_23 |-> st[0][22:0] != 23'h000000;
  endproperty
  a_p23: assert property (p_p23) else $error("medium stuck");
  property p_p31;
    pat_q[1] == tpa_pkg::PAT_31 && ctrl.pat1 == tpa_pkg::PAT_31 && fire
      |=> st[1] != $past(st[1]) && st[1] != 31'h00000000;
  endproperty
  a_p31: assert property (p_p31) else $error("long stuck");
  property p_bhold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
endmodule // tpa_top

// >>> tx_phase_align_polarity_prbs_tb_top.sv
// Self-checking bench: registers, data path, FIFO, patterns, alignment.
// Assumes one clock; the line sink model takes words at random.
`timescale 1ns/1ps
module tx_phase_align_polarity_prbs_tb_top;
  localparam logic [3:0] CA = tpa_pkg::CTRL_OFS;
  localparam logic [3:0] SA = tpa_pkg::STAT_OFS;
  logic I_CLK = 0, I_RST_N = 0, I_AWVALID = 0, I_WVALID = 0, I_BREADY = 0;
  logic I_ARVALID = 0, I_RREADY = 0, I_TX_VALID = 0, stall = 0;
  logic [3:0] I_AWADDR = 0, I_ARADDR = 0, I_WSTRB = 4'hF;
  logic [31:0] I_WDATA = 0, O_RDATA, rd;
  logic [19:0] I_TX_DATA = 0;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_TX_READY;
  logic O_WORD_VALID, O_WIDTH10, O_BUF_USE, O_ALIGNED, I_LINE_READY;
  logic [1:0] O_BRESP, O_RRESP, O_LINE_DIV, rsp;
  logic [9:0] O_CH0_WORD, O_CH1_WORD;
  logic [19:0] exp_q[$];
  tpa_pkg::tpa_ctrl_t c;
  int bad_count = 0, cmp_count = 0, cyc = 0;
  int dg[4] = '{0, 7, 23, 31};
  int tp[4] = '{0, 6, 18, 28};

  tpa_top #(.DEPTH(32)) tpa_top_i (.I_CLK, .I_RST_N, .I_AWVALID, .O_AWREADY,
    .I_AWADDR, .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB, .O_BVALID,
    .I_BREADY, .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID,
    .I_RREADY, .O_RDATA, .O_RRESP, .I_TX_VALID, .O_TX_READY, .I_TX_DATA,
    .I_LINE_READY, .O_WORD_VALID, .O_CH0_WORD, .O_CH1_WORD, .O_LINE_DIV,
    .O_WIDTH10, .O_BUF_USE, .O_ALIGNED);
  tpa_line_sink tpa_line_sink_i (.i_clk(I_CLK), .i_valid(O_WORD_VALID),
    .i_word({O_CH1_WORD, O_CH0_WORD}), .i_stall(stall),
    .o_ready(I_LINE_READY));

  // Clock
  initial forever #5 I_CLK = ~I_CLK;

  // Cut a hang short
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t flag %b expected %b", $time, g, e);
    end
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    I_AWVALID <= 1;
    I_WVALID <= 1;
    I_AWADDR <= a;
    I_WDATA <= d;
    I_BREADY <= 1;
    do begin
      @(posedge I_CLK);
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 0;
      if (I_WVALID && O_WREADY) I_WVALID <= 0;
    end while (!O_BVALID);
    rsp = O_BRESP;
    I_BREADY <= 0;
  endtask

  // AXI4-Lite read
  task automatic rdr(input logic [3:0] a);
    @(posedge I_CLK);
    I_ARVALID <= 1;
    I_ARADDR <= a;
    I_RREADY <= 1;
    do begin
      @(posedge I_CLK);
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 0;
    end while (!O_RVALID);
    rd = O_RDATA;
    rsp = O_RRESP;
    I_RREADY <= 0;
  endtask

  task automatic setc();
    wr(CA, {20'h0, c});
  endtask

  // Offer n random user words, each held until taken
  task automatic send(input int n);
    @(posedge I_CLK);
    for (int i = 0; i < n; i++) begin
      I_TX_VALID <= 1;
      I_TX_DATA <= 20'($urandom);
      do @(posedge I_CLK); while (!O_TX_READY);
      exp_q.push_back(I_TX_DATA);
    end
    I_TX_VALID <= 0;
  endtask

  task automatic drain();
    while (tpa_line_sink_i.q.size() < exp_q.size()) @(posedge I_CLK);
  endtask

  function automatic logic [19:0] xf(input logic [19:0] d);
    logic [9:0] a;
    logic [9:0] b;
    a = d[9:0] ^ {10{c.pol0}};
    b = d[19:10] ^ {10{c.pol1}};
    if (!c.width10) begin
      a[9:8] = 2'h0;
      b[9:8] = 2'h0;
    end
    return {b, a};
  endfunction

  task automatic cmp_words();
    drain();
    foreach (exp_q[i])
      chk32({12'h0, tpa_line_sink_i.q[i]}, {12'h0, xf(exp_q[i])});
    exp_q.delete();
    tpa_line_sink_i.q.delete();
  endtask

  // Bit stream, first bit is word bit 9, must keep the inverted recurrence
  task automatic prbs(input int d, input int t);
    logic s[$];
    logic [19:0] w;
    int err;
    err = 0;
    drain();
    for (int ch = 0; ch < 2; ch++) begin
      s.delete();
      for (int i = 2; i < tpa_line_sink_i.q.size(); i++) begin
        w = tpa_line_sink_i.q[i] ^ {{10{c.pol1}}, {10{c.pol0}}};
        for (int b = 9; b >= 0; b--) s.push_back(w[ch * 10 + b]);
      end
      for (int n = d; n < s.size(); n++)
        if (s[n] !== ~(s[n - d] ^ s[n - t])) err++;
      if (!(1'b0 inside {s})) err++;
    end
    chk32(32'(err), 32'h0);
    exp_q.delete();
    tpa_line_sink_i.q.delete();
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h8B4A281E));
    repeat (8) @(posedge I_CLK);
    I_RST_N <= 1;
    rdr(CA);
    chk32(rd, {20'h0, tpa_pkg::CTRL_RST});
    rdr(SA);
    chk32(rd, 32'h2);
    rdr(4'h8);
    chk32({30'h0, rsp}, {30'h0, tpa_pkg::RESP_SLVERR});
    chk1(O_WIDTH10, 1'b0);
    // Unmapped write refused, then a write through the upper strobe only
    wr(4'hC, 32'h0);
    chk32({30'h0, rsp}, {30'h0, tpa_pkg::RESP_SLVERR});
    I_WSTRB <= 4'h2;
    wr(CA, 32'h5FF);
    I_WSTRB <= 4'hF;
    chk32({30'h0, rsp}, {30'h0, tpa_pkg::RESP_OKAY});
    chk32({30'h0, O_LINE_DIV}, {30'h0, tpa_pkg::DIV4});
    rdr(CA);
    chk32(rd, 32'h500);
    chk32({30'h0, rsp}, {30'h0, tpa_pkg::RESP_OKAY});
    // Polarity and width on user data
    for (int k = 0; k < 4; k++) begin
      c = '0;
      c.buf_use = 1;
      c.width10 = (k != 0);
      c.pol0 = k[0];
      c.pol1 = k[1];
      setc();
      chk1(O_WIDTH10, c.width10);
      send(20);
      cmp_words();
    end
    // Fill until refused while the far side stalls, then drain
    stall <= 1;
    repeat (3) @(posedge I_CLK);
    I_TX_VALID <= 1;
    I_TX_DATA <= 20'($urandom);
    do begin
      @(posedge I_CLK);
      if (O_TX_READY) begin
        exp_q.push_back(I_TX_DATA);
        I_TX_DATA <= 20'($urandom);
      end
    end while (O_TX_READY);
    chk1(exp_q.size() >= 32, 1'b1);
    rdr(SA);
    chk32(rd & 32'h6, 32'h4);
    stall <= 0;
    do @(posedge I_CLK); while (!O_TX_READY);
    exp_q.push_back(I_TX_DATA);
    I_TX_VALID <= 0;
    cmp_words();
    rdr(SA);
    chk32(rd & 32'h6, 32'h2);
    // Every pattern code on both channels, 10-bit path
    for (int p = 1; p < 4; p++) begin
      c = '0;
      c.buf_use = 1;
      c.width10 = 1;
      c.pat0 = p[1:0];
      c.pat1 = p[1:0];
      c.pol0 = 1;
      setc();
      repeat (3) @(posedge I_CLK);
      send(14);
      prbs(dg[p], tp[p]);
    end
    c.width10 = 0;
    setc();
    rdr(SA);
    chk32(rd & 32'h8, 32'h8);
    // Alignment: bypass at divide 2, then buffered at divide 1
    for (int m = 0; m < 2; m++) begin
      c = '0;
      c.width10 = 1;
      c.buf_use = m[0];
      c.com_div = m ? tpa_pkg::DIV1 : tpa_pkg::DIV2;
      c.phase_en = 1;
      setc();
      chk1(O_BUF_USE, c.buf_use);
      chk32({30'h0, O_LINE_DIV}, {30'h0, c.com_div});
      repeat (512) @(posedge I_CLK);
      c.set_phase = 1;
      setc();
      repeat (m ? 16384 : 8192) @(posedge I_CLK);
      c.set_phase = 0;
      setc();
      repeat (2) @(posedge I_CLK);
      chk1(O_ALIGNED, 1'b1);
      rdr(SA);
      chk32(rd & 32'h1, 32'h1);
      c.phase_en = 0;
      setc();
      repeat (2) @(posedge I_CLK);
      chk1(O_ALIGNED, 1'b0);
    end
    // One reset pulse once the buffered alignment is done
    I_RST_N <= 0;
    repeat (2) @(posedge I_CLK);
    I_RST_N <= 1;
    @(posedge I_CLK);
    chk1(O_BUF_USE, 1'b1);
    chk1(O_ALIGNED, 1'b0);
    chk1(O_WORD_VALID, 1'b0);
    rdr(CA);
    chk32(rd, {20'h0, tpa_pkg::CTRL_RST});
    end_of_test();
  end
endmodule // tx_phase_align_polarity_prbs_tb_top
